// ---- rtl/sq_pkg.sv ----
// package for the 16-step pattern sequencer: register map, field layout, timing and carrier types
// assumes a single 100 MHz ref_clk and an avalon-mm slave with byte addresses
//
// Functional notes
// - start acts only while reset is inactive
// - start low freezes step, counts and outputs, except a jog advance in the event variant
// - event variant: jog rising edge advances one step
// - reset beats start, holds preset, no counting
// - preset step 1..16, entered on reset and on non-retentive run entry
// - per-step count up to 9999 timebase units
// - four status counters from selectable base number
// - optional per-step event input as transition condition
// - outputs driven whenever run mode is active
// - non-retentive run entry zeroes counts, loads preset
// - retentive option is the default
// - last step done sets completion flag, holds step
// - reset clears completion flag, enters preset step
// - jog while running advances, clears timer
// - jog in last step completes the sequence
// - timed variant: count 0 marks an unused step
// - 16 steps, each with 16-bit output pattern
// - software may rewrite preset any time, rest read-only
// - first counter status bit is completion flag
// - counters: elapsed, timer, preset, current step
// - event plus count: timer runs only while event true
// - timebase 0.01..99.99 s per count
package sq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int unsigned SQ_STEPS     = 16;            // steps per sequence
  localparam int unsigned SQ_OUTS      = 16;            // outputs per step
  localparam int unsigned SQ_EVENTS    = 16;            // discrete event lines
  localparam logic [15:0] SQ_MAX_COUNT = 16'd9999;      // counts per step ceiling
  localparam logic [15:0] SQ_MAX_TBASE = 16'd9999;      // timebase ceiling, 99.99 s
  localparam logic [6:0]  SQ_MAX_BASE  = 7'o174;        // highest counter base number

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam longint unsigned SQ_CLK_PERIOD_NS  = 10;        // ref_clk period
  localparam longint unsigned SQ_TICK_PERIOD_NS = 10000000;  // 0.01 s tick
  localparam int unsigned SQ_TICK_CYCLES = int'(SQ_TICK_PERIOD_NS / SQ_CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] SQ_OFF_CTRL    = 8'h00;  // option bits
  localparam logic [7:0] SQ_OFF_TBASE   = 8'h04;  // timebase in 0.01 s units
  localparam logic [7:0] SQ_OFF_STATUS  = 8'h08;  // flag and state
  localparam logic [7:0] SQ_OFF_BASE    = 8'h0c;  // counter base number
  localparam logic [7:0] SQ_OFF_ELAPSED = 8'h10;  // step_elapsed_count
  localparam logic [7:0] SQ_OFF_TIMER   = 8'h14;  // step_timer_value
  localparam logic [7:0] SQ_OFF_PRESET  = 8'h18;  // preset_step_number
  localparam logic [7:0] SQ_OFF_CURRENT = 8'h1c;  // current_step_number
  localparam logic [7:0] SQ_OFF_COUNTS  = 8'h40;  // 16 words, counts per step
  localparam logic [7:0] SQ_OFF_EVCFG   = 8'h80;  // 16 words, event select
  localparam logic [7:0] SQ_OFF_PATTERN = 8'hc0;  // 16 words, output pattern

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned SQ_CTRL_NONRET = 0;  // 1: non-retentive init
  localparam int unsigned SQ_CTRL_EVENT  = 1;  // 1: event-capable variant
  localparam int unsigned SQ_EV_EN       = 4;  // event assigned
  localparam int unsigned SQ_ST_DONE     = 0;  // completion flag
  localparam int unsigned SQ_ST_RUNMODE  = 1;  // run mode seen
  localparam int unsigned SQ_ST_ACTIVE   = 2;  // start effective

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [1:0]  SQ_RST_CTRL   = 2'h0;   // retentive, timed-only
  localparam logic [15:0] SQ_RST_TBASE  = 16'h1;  // 0.01 s per count
  localparam logic [6:0]  SQ_RST_BASE   = 7'h0;
  localparam logic [4:0]  SQ_RST_PRESET = 5'h1;   // step 1

  // synchronised control inputs
  typedef struct packed {
    logic run_mode;
    logic start;
    logic jog;
    logic reset;
  } sq_ctl_s;

  // step machine
  typedef enum logic [1:0] {
    SQ_PROG,
    SQ_RUN,
    SQ_DONE
  } sq_state_e;

endpackage : sq_pkg

// ---- rtl/sq_sync.sv ----
// three-stage input synchroniser with agreement filter
// assumes inputs may change at any time relative to ref_clk
module sq_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;  // metastable stage, read only by s2
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;   // filtered level

  // a bit changes only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
    end
  end

  assign dout = q_r;

endmodule // sq_sync

// ---- rtl/sq_tick_div.sv ----
// divider giving a one-cycle tick enable at a fixed cycle count
// assumes CYCLES of at least one
module sq_tick_div #(
  parameter int unsigned CYCLES = 1000000
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  output logic      tick
);

  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;  // cycles since last tick
  logic          tick_r;

  // wrap at LAST and pulse for one cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      tick_r <= (cnt_r == LAST);
    end
  end

  assign tick = tick_r;

endmodule // sq_tick_div

// ---- rtl/sq_step_sequencer.sv ----
// 16-step, 16-output pattern sequencer with timed and event transitions
// assumes ladder-side inputs and event lines are asynchronous; avalon-mm master on ref_clk
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
module sq_step_sequencer #(
  parameter int unsigned TICK_CYCLES = sq_pkg::SQ_TICK_CYCLES  // 0.01 s tick, shorten in simulation
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // ladder-side controls
  input  wire logic        run_mode,
  input  wire logic        start,
  input  wire logic        jog,
  input  wire logic        seq_reset,
  input  wire logic [15:0] event_in,
  // discrete outputs and flag
  output logic      [15:0] out_pattern,
  output logic             completion_flag,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  import sq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration storage
  logic [15:0] counts_r  [SQ_STEPS];  // counts per step, 0 = none
  logic [4:0]  evcfg_r   [SQ_STEPS];  // enable and event index
  logic [15:0] pattern_r [SQ_STEPS];  // output pattern per step
  logic [1:0]  ctrl_r;                // non-retentive, event variant
  logic [15:0] tbase_r;               // ticks per count
  logic [6:0]  base_r;                // counter base number
  logic [4:0]  preset_r;              // preset step 1..16

  // sequencer state
  sq_state_e   state_r;
  logic [15:0] elapsed_r;             // counts in step
  logic [15:0] timer_r;               // ticks in present count
  logic [4:0]  cur_r;                 // current step 1..16
  logic        done_r;                // completion flag
  logic        jog_d_r;               // previous jog level
  logic        run_d_r;               // previous run level
  logic [15:0] out_r;                 // driven pattern

  // bus slave state
  logic        ack_r;                 // answer cycle
  logic [31:0] rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and tick
  sq_ctl_s     ctl;                   // filtered controls
  logic [15:0] ev_s;                  // filtered events
  logic        tick;                  // 10 ms enable

  sq_sync #(.W(4)) u_ctl_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     ({run_mode, start, jog, seq_reset}),
    .dout    (ctl)
  );

  sq_sync #(.W(16)) u_ev_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     (event_in),
    .dout    (ev_s)
  );

  sq_tick_div #(.CYCLES(TICK_CYCLES)) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // step decode
  wire  [3:0]  cur_idx    = 4'(cur_r - 5'd1);
  wire  [15:0] cur_counts = counts_r[cur_idx];
  wire  [4:0]  cur_ev     = evcfg_r[cur_idx];
  wire         ev_variant = ctrl_r[SQ_CTRL_EVENT];
  wire         has_event  = ev_variant & cur_ev[SQ_EV_EN];        // timed variant ignores events
  wire         ev_true    = ev_s[cur_ev[3:0]];
  wire         has_count  = (cur_counts != 16'h0);
  wire         run_entry  = ctl.run_mode & ~run_d_r;
  wire         jog_edge   = ctl.jog & ~jog_d_r & ev_variant;
  wire         rst_act    = ctl.reset;
  wire         start_act  = ctl.start & ~rst_act;
  wire  [15:0] tb_eff     = (tbase_r == 16'h0) ? 16'h1 : tbase_r; // zero runs at one tick
  wire         count_pass = (timer_r + 16'h1) >= tb_eff;

  // last used step: highest step with a count or an event
  logic [4:0]  last_step;
  always_comb begin
    last_step = 5'd1;
    for (int i = 0; i < SQ_STEPS; i++) begin
      if (counts_r[i] != 16'h0 || (ev_variant && evcfg_r[i][SQ_EV_EN])) begin
        last_step = 5'(i + 1);
      end
    end
  end
  wire         at_last    = (cur_r >= last_step);

  // timer runs only while start is effective and event, if any, is true
  wire         time_run   = start_act & has_count & (~has_event | ev_true) & tick;
  // step end by time, by event alone, or skip of an unused step
  wire         time_end   = time_run & count_pass & ((elapsed_r + 16'h1) >= cur_counts);
  wire         event_end  = start_act & has_event & ~has_count & ev_true;
  wire         skip_end   = start_act & ~has_count & ~has_event;
  wire         step_end   = time_end | event_end | skip_end;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  sq_state_e   state_nxt;
  logic [15:0] elapsed_nxt;
  logic [15:0] timer_nxt;
  logic [4:0]  cur_nxt;
  logic        done_nxt;

  always_comb begin
    state_nxt   = state_r;
    elapsed_nxt = elapsed_r;
    timer_nxt   = timer_r;
    cur_nxt     = cur_r;
    done_nxt    = done_r;
    case (state_r)
      SQ_PROG: begin
        if (run_entry) begin
          state_nxt = done_r ? SQ_DONE : SQ_RUN;            // retentive keeps all
          if (ctrl_r[SQ_CTRL_NONRET]) begin
            elapsed_nxt = 16'h0;
            timer_nxt   = 16'h0;
            cur_nxt     = preset_r;
            done_nxt    = 1'b0;
            state_nxt   = SQ_RUN;
          end
        end
      end
      SQ_RUN, SQ_DONE: begin
        if (!ctl.run_mode) begin
          state_nxt = SQ_PROG;                              // leave run, state kept
        end else if (rst_act) begin
          elapsed_nxt = 16'h0;                              // held in preset
          timer_nxt   = 16'h0;
          cur_nxt     = preset_r;
          done_nxt    = 1'b0;
          state_nxt   = SQ_RUN;
        end else if (state_r == SQ_DONE) begin
          state_nxt = SQ_DONE;                              // start and jog ignored
        end else if (jog_edge || step_end) begin
          elapsed_nxt = 16'h0;
          timer_nxt   = 16'h0;
          if (at_last) begin
            done_nxt  = 1'b1;                               // step stays at last
            state_nxt = SQ_DONE;
          end else begin
            cur_nxt   = cur_r + 5'd1;
          end
        end else if (time_run) begin
          if (count_pass) begin
            timer_nxt   = 16'h0;                            // timebase multiplies counts
            elapsed_nxt = elapsed_r + 16'h1;
          end else begin
            timer_nxt   = timer_r + 16'h1;
          end
        end
        // start low leaves everything frozen except a jog edge in the event variant
      end
      default: begin
        state_nxt = SQ_PROG;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r   <= SQ_PROG;
      elapsed_r <= 16'h0;
      timer_r   <= 16'h0;
      cur_r     <= SQ_RST_PRESET;
      done_r    <= 1'b0;
      jog_d_r   <= 1'b0;
      run_d_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      elapsed_r <= elapsed_nxt;
      timer_r   <= timer_nxt;
      cur_r     <= cur_nxt;
      done_r    <= done_nxt;
      jog_d_r   <= ctl.jog;
      run_d_r   <= ctl.run_mode;
    end
  end

  // outputs follow the present step whenever run mode holds
  wire  [15:0] out_nxt = ctl.run_mode ? pattern_r[4'(cur_nxt - 5'd1)] : 16'h0;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_r <= 16'h0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign out_pattern     = out_r;
  assign completion_flag = done_r;                          // first counter status bit

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle, answer on the second
  wire         req      = avs_read | avs_write;
  wire         wr_go    = avs_write & ack_r;                // write lands on the edge waitrequest is low
  wire  [1:0]  grp      = avs_address[7:6];                 // table select
  wire  [3:0]  tidx     = avs_address[5:2];
  wire         a_ctrl   = (avs_address == SQ_OFF_CTRL);
  wire         a_tbase  = (avs_address == SQ_OFF_TBASE);
  wire         a_status = (avs_address == SQ_OFF_STATUS);
  wire         a_base   = (avs_address == SQ_OFF_BASE);
  wire         a_elap   = (avs_address == SQ_OFF_ELAPSED);
  wire         a_timer  = (avs_address == SQ_OFF_TIMER);
  wire         a_preset = (avs_address == SQ_OFF_PRESET);
  wire         a_cur    = (avs_address == SQ_OFF_CURRENT);
  wire         a_aligned= (avs_address[1:0] == 2'b00);
  wire         a_cnt    = a_aligned & (grp == SQ_OFF_COUNTS[7:6]);
  wire         a_evc    = a_aligned & (grp == SQ_OFF_EVCFG[7:6]);
  wire         a_pat    = a_aligned & (grp == SQ_OFF_PATTERN[7:6]);
  wire  [15:0] wmask    = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire  [15:0] wd16     = avs_writedata[15:0];
  wire  [4:0]  wpreset  = avs_writedata[4:0];
  wire         preset_ok= avs_byteenable[0] & (wpreset >= 5'd1) & (wpreset <= 5'd16)
                          & (avs_writedata[15:5] == 11'h0);

  assign avs_waitrequest = req & ~ack_r;

  // read data mux, counters in monitor order
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0;                                      // unmapped reads zero
    if (a_ctrl)        rdata_nxt = {30'h0, ctrl_r};
    else if (a_tbase)  rdata_nxt = {16'h0, tbase_r};
    else if (a_status) rdata_nxt = {29'h0, start_act, ctl.run_mode, done_r};
    else if (a_base)   rdata_nxt = {25'h0, base_r};
    else if (a_elap)   rdata_nxt = {16'h0, elapsed_r};
    else if (a_timer)  rdata_nxt = {16'h0, timer_r};
    else if (a_preset) rdata_nxt = {27'h0, preset_r};
    else if (a_cur)    rdata_nxt = {27'h0, cur_r};
    else if (a_cnt)    rdata_nxt = {16'h0, counts_r[tidx]};
    else if (a_evc)    rdata_nxt = {27'h0, evcfg_r[tidx]};
    else if (a_pat)    rdata_nxt = {16'h0, pattern_r[tidx]};
  end

  // handshake and read capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r   <= req & ~ack_r;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;

  // scalar writes; only the preset counter is writable of the four
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r   <= SQ_RST_CTRL;                              // retentive default
      tbase_r  <= SQ_RST_TBASE;
      base_r   <= SQ_RST_BASE;
      preset_r <= SQ_RST_PRESET;
    end else if (wr_go) begin
      if (a_ctrl && avs_byteenable[0]) ctrl_r <= avs_writedata[1:0];
      if (a_tbase && (wd16 & wmask | tbase_r & ~wmask) <= SQ_MAX_TBASE)
        tbase_r <= (wd16 & wmask) | (tbase_r & ~wmask);
      if (a_base && avs_byteenable[0] && avs_writedata[6:0] <= SQ_MAX_BASE)
        base_r <= avs_writedata[6:0];
      if (a_preset && preset_ok) preset_r <= wpreset;
    end
  end

  // step tables; counts above the ceiling are refused
  wire  [15:0] cnt_merge = (wd16 & wmask) | (counts_r[tidx] & ~wmask);
  wire  [15:0] pat_merge = (wd16 & wmask) | (pattern_r[tidx] & ~wmask);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SQ_STEPS; i++) begin
        counts_r[i]  <= 16'h0;                              // unused by default
        evcfg_r[i]   <= 5'h0;
        pattern_r[i] <= 16'h0;
      end
    end else if (wr_go) begin
      if (a_cnt && cnt_merge <= SQ_MAX_COUNT) counts_r[tidx] <= cnt_merge;
      if (a_evc && avs_byteenable[0]) evcfg_r[tidx] <= avs_writedata[4:0];
      if (a_pat) pattern_r[tidx] <= pat_merge;
    end
  end

endmodule // sq_step_sequencer

// ---- sim/sq_step_sequencer_sva.sv ----
// checker for the step sequencer ports: bus handshake, output gating, flag causes, ranges
// assumes a bind onto sq_step_sequencer, one clock, synchronous active-low rst_n
module sq_seq_sva
  import sq_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        run_mode,
  input wire logic        seq_reset,
  input wire logic [15:0] out_pattern,
  input wire logic        completion_flag,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////
  // recent pin history; the syncs delay a cause by several edges
  logic [5:0] cause_r;                                  // reset or program mode seen
  wire        rd_ok = avs_read & ~avs_waitrequest;      // read answered now
  always_ff @(posedge ref_clk) begin
    cause_r <= {cause_r[4:0], seq_reset | ~run_mode};
  end

  ////////////////////////////////////////////////////////////
  a_wait_first: assert property (
    $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest) else $error("no wait on new request");
  a_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
  a_idle_nowait: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait while idle");
  a_unmapped_zero: assert property (
    rd_ok && avs_address inside {[8'h20:8'h3f]} |-> avs_readdata == 32'h0) else $error("unmapped read");
  a_preset_range: assert property (
    rd_ok && avs_address == SQ_OFF_PRESET |-> avs_readdata inside {[32'h1:32'h10]}) else $error("preset range");
  a_current_range: assert property (
    rd_ok && avs_address == SQ_OFF_CURRENT |-> avs_readdata inside {[32'h1:32'h10]}) else $error("step range");
  a_status_flag: assert property (
    rd_ok && avs_address == SQ_OFF_STATUS |-> avs_readdata[SQ_ST_DONE] == completion_flag)
    else $error("status flag differs");
  a_count_limit: assert property (
    rd_ok && avs_address == SQ_OFF_ELAPSED |-> avs_readdata <= 32'd9999) else $error("elapsed above limit");
  a_out_gated: assert property (
    !run_mode [*6] |=> out_pattern == 16'h0) else $error("outputs live out of run");
  a_flag_cause: assert property (
    $fell(completion_flag) |-> |cause_r) else $error("flag dropped without reset");
endmodule // sq_seq_sva

// ---- sim/sq_ladder_model.sv ----
// ladder-side partner: drives run mode, start, jog and sequencer reset levels
// assumes the bench calls its tasks; every change lands by nonblocking assignment on ref_clk
module sq_ladder_model (
  input  wire logic ref_clk,
  output logic      run_mode,
  output logic      start,
  output logic      jog,
  output logic      seq_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    run_mode  = 1'b0;  // program mode at power-up
    start     = 1'b0;
    jog       = 1'b0;
    seq_reset = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // level change, then room for the syncs and the output register
  task automatic set_ctl(input logic rm, input logic st, input logic rs);
    @(posedge ref_clk);
    run_mode  <= rm;
    start     <= st;
    seq_reset <= rs;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // one jog edge; low time kept well above the two-cycle minimum
  task automatic jog_pulse();
    @(posedge ref_clk);
    jog <= 1'b1;
    repeat (5) @(posedge ref_clk);
    jog <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
endmodule // sq_ladder_model

// ---- sim/sq_step_sequencer_tb_top.sv ----
// top bench: avalon master, expected-read queue with a watching monitor, sequence scenarios
// assumes sq_pkg, sq_step_sequencer and the ladder model; TICK_CYCLES shortened to 4
module sq_step_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sq_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, run_mode, start, jog, seq_reset, completion_flag;
  logic [15:0] event_in = 16'h0, out_pattern;
  logic [7:0]  avs_address = 8'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [15:0] exp_q[$];           // expected read values, oldest first
  logic [15:0] pat[3];             // random patterns of the three used steps
  int          err_total = 0, n_checks = 0, n;
  integer      seed = 32'ha4c9;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) event_in <= 16'($random(seed));  // no step watches them yet

  sq_step_sequencer #(.TICK_CYCLES(4)) i_sq_step_sequencer (.ref_clk, .rst_n, .run_mode, .start, .jog,
    .seq_reset, .event_in, .out_pattern, .completion_flag, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  sq_ladder_model i_sq_ladder_model (.ref_clk, .run_mode, .start, .jog, .seq_reset);

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one avalon transfer; waitrequest sampled at each rising edge, request held until it is low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      k++;
      @(posedge ref_clk);
    end
    if (k == 50) chk(32'h1, 32'h0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // monitor: each answered read takes the oldest note at the accepting edge
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) chk(32'hffff, 32'h0);
      else chk(avs_readdata, {16'h0, exp_q.pop_front()});
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(SQ_OFF_CTRL, 16'h0);
    rd(SQ_OFF_ELAPSED, 16'h0);
    rd(SQ_OFF_TIMER, 16'h0);
    rd(SQ_OFF_PRESET, 16'h1);
    rd(SQ_OFF_CURRENT, 16'h1);
    rd(8'h20, 16'h0);
    bus(1'b1, SQ_OFF_PRESET, 32'h11);
    rd(SQ_OFF_PRESET, 16'h1);
    bus(1'b1, SQ_OFF_ELAPSED, 32'h5);
    rd(SQ_OFF_ELAPSED, 16'h0);
    bus(1'b1, SQ_OFF_PRESET, 32'h10);
    rd(SQ_OFF_PRESET, 16'h10);
    bus(1'b1, SQ_OFF_PRESET, 32'h1);
    bus(1'b1, SQ_OFF_COUNTS, 32'd10000);
    rd(SQ_OFF_COUNTS, 16'h0);
    bus(1'b1, SQ_OFF_COUNTS, 32'd9999);
    rd(SQ_OFF_COUNTS, 16'd9999);
    // three one-count steps; the rest stay unused
    for (int i = 0; i < 3; i++) begin
      pat[i] = 16'($random(seed));
      bus(1'b1, SQ_OFF_COUNTS + 8'(4 * i), 32'h1);
      bus(1'b1, SQ_OFF_PATTERN + 8'(4 * i), {16'h0, pat[i]});
    end
    i_sq_ladder_model.set_ctl(1'b1, 1'b0, 1'b0);
    chk(out_pattern, pat[0]);
    rd(SQ_OFF_CURRENT, 16'h1);
    i_sq_ladder_model.set_ctl(1'b1, 1'b1, 1'b0);
    n = 0;
    while (completion_flag !== 1'b1 && n < 500) begin
      n++;
      @(negedge ref_clk);
    end
    chk(completion_flag, 1'b1);
    chk(out_pattern, pat[2]);
    rd(SQ_OFF_CURRENT, 16'h3);
    i_sq_ladder_model.set_ctl(1'b1, 1'b1, 1'b1);
    chk(completion_flag, 1'b0);
    chk(out_pattern, pat[0]);
    rd(SQ_OFF_CURRENT, 16'h1);
    // event variant, start off: jogs walk the steps and finish the sequence
    bus(1'b1, SQ_OFF_CTRL, 32'h2);
    i_sq_ladder_model.set_ctl(1'b1, 1'b0, 1'b0);
    i_sq_ladder_model.jog_pulse();
    rd(SQ_OFF_CURRENT, 16'h2);
    rd(SQ_OFF_TIMER, 16'h0);
    i_sq_ladder_model.jog_pulse();
    i_sq_ladder_model.jog_pulse();
    chk(completion_flag, 1'b1);
    rd(SQ_OFF_CURRENT, 16'h3);
    // non-retentive re-entry into run mode
    bus(1'b1, SQ_OFF_CTRL, 32'h3);
    i_sq_ladder_model.set_ctl(1'b0, 1'b0, 1'b0);
    chk(out_pattern, 16'h0);
    i_sq_ladder_model.set_ctl(1'b1, 1'b0, 1'b0);
    rd(SQ_OFF_CURRENT, 16'h1);
    rd(SQ_OFF_ELAPSED, 16'h0);
    chk(out_pattern, pat[0]);
    complete_run();
  end
endmodule // sq_step_sequencer_tb_top

bind sq_step_sequencer sq_seq_sva i_sq_seq_sva (.ref_clk, .rst_n, .run_mode, .seq_reset, .out_pattern,
  .completion_flag, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);
